// >>> logic/law_pkg.sv
// holds constants, register map and state encoding for the 32-bit page walker
// assumes a single core clock domain; offsets are Avalon-MM word indices
//
// Functional notes
// - walk only when translation_on=1, wide_entry_mode=0
// - 32-bit linear in, up to 40-bit physical
// - upper bits 39:32 zero except 4-MByte pages
// - no extended large-page: 4-MByte upper bits zero
// - zero 4-MByte bits from width up to 39
// - directory base from base register bits 31:12
// - base write-through/cache-disable drive directory reads
// - base bits 2:0, 11:5, 63:32 ignored
// - directory entry address: base, linear 31:22, zeros
// - directory holds 1024 32-bit entries
// - large page needs enable and size_flag bit 7
// - large page: 39:32 from 20:13, 31:22, offset
// - large page entry needs present bit 0
// - report write-permit and user-permit flags
// - large entry pwt/pcd drive page memory type
// - bit 5 accessed, bit 6 dirty
// - global bit 8 only with global_pages_enable
// - bit 12 memtype index, else reserved zero
// - physical M-1:32 from entry; 21:M-19 reserved
// - otherwise fetch table at entry bits 31:12
// - table entry address and 4-KByte final address
// - fault on not present or reserved bit set
// - M is 32, or min(40, phys width)
package law_pkg;
   localparam int LIN_W   = 32;
   localparam int PHYS_W  = 40;
   localparam int ENTRY_W = 32;
   localparam int NUM_DIR_ENTRIES = 1024;
   localparam int MAX_M   = 40;
   localparam int BASE_M  = 32;

   // register word indices
   localparam logic [1:0] REG_BASE_LO_IDX = 2'h0;
   localparam logic [1:0] REG_BASE_HI_IDX = 2'h1;
   localparam logic [1:0] REG_CTRL_IDX    = 2'h2;
   localparam logic [1:0] REG_STATUS_IDX  = 2'h3;

   // control register bits
   localparam int CTRL_TRANSLATION_ON = 0;
   localparam int CTRL_WIDE_ENTRY     = 1;
   localparam int CTRL_LARGE_PAGE     = 2;
   localparam int CTRL_GLOBAL_PAGES   = 3;
   localparam int CTRL_SUP_WP         = 4;
   localparam int CTRL_W              = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam logic [63:0] BASE_RESET = 64'h0000000000000000;

   // entry fields
   localparam int E_PRESENT = 0;
   localparam int E_WRITE   = 1;
   localparam int E_USER    = 2;
   localparam int E_PWT     = 3;
   localparam int E_PCD     = 4;
   localparam int E_ACC     = 5;
   localparam int E_DIRTY   = 6;
   localparam int E_SIZE    = 7;
   localparam int E_GLOBAL  = 8;
   localparam int E_PAT_4K  = 7;
   localparam int E_PAT_4M  = 12;
   localparam int E_HI_LSB  = 13;
   localparam int E_RSV_MSB = 21;
   localparam int E_FRAME_LSB = 12;
   localparam int E_LARGE_LSB = 22;
   localparam int HI_SHIFT  = 19;

   localparam int LIN_DIR_LSB = 22;
   localparam int LIN_TBL_LSB = 12;
   localparam int IDX_W       = 10;

   typedef enum logic [1:0] {
      LAW_IDLE = 2'b00,
      LAW_DIR  = 2'b01,
      LAW_TBL  = 2'b11,
      LAW_RESP = 2'b10
   } law_state_t;
endpackage

// >>> logic/law_walk.sv
// 32-bit paging walker: directory base and mode controls over Avalon-MM,
// translation requests from a core, paging-entry reads from memory.
// assumes memory answers each read with a one-cycle ack carrying the entry.
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module law_walk
   import law_pkg::*;
#(
   parameter int PHYS_WIDTH_PARAM = 40,
   parameter bit HAS_EXT_LARGE    = 1'b1,
   parameter bit HAS_PAT          = 1'b1
) (
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   // register bus
   input  wire logic [1:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest,
   // translation requests
   input  wire logic               req_valid,
   output logic                    req_ready,
   input  wire logic [LIN_W-1:0]   req_lin_addr,
   output logic                    rsp_valid,
   input  wire logic               rsp_ready,
   output logic [PHYS_W-1:0]       rsp_phys_addr,
   output logic                    rsp_fault,
   output logic                    rsp_untranslated,
   output logic                    rsp_large_page,
   output logic                    rsp_write_permit,
   output logic                    rsp_user_permit,
   output logic                    rsp_write_through_attr,
   output logic                    rsp_cache_disable_attr,
   output logic                    rsp_memtype_index_bit,
   output logic                    rsp_accessed,
   output logic                    rsp_dirty,
   output logic                    rsp_global,
   // paging-entry reads
   output logic                    mem_rd_req,
   output logic [PHYS_W-1:0]       mem_rd_addr,
   output logic                    mem_rd_write_through_attr,
   output logic                    mem_rd_cache_disable_attr,
   input  wire logic               mem_rd_ack,
   input  wire logic [ENTRY_W-1:0] mem_rd_data
);
   // -----------------------------------------------------------------
   // width of large-page frame bits
   // -----------------------------------------------------------------
   localparam int M_W = HAS_EXT_LARGE ?
      ((PHYS_WIDTH_PARAM < MAX_M) ? PHYS_WIDTH_PARAM : MAX_M) : BASE_M;

   // entry address: frame base in 31:12, index in 11:2, zero elsewhere
   // used for both levels, so bits 39:32 can never leak
   function automatic logic [PHYS_W-1:0] entry_addr(input logic [19:0] frame,
                                                     input logic [IDX_W-1:0] idx);
      entry_addr = {8'h00, frame, idx, 2'b00};
   endfunction

   // reserved bits of a large-page entry
   // width-dependent: with M at 40 only bit 21 stays reserved
   function automatic logic large_rsv(input logic [ENTRY_W-1:0] e);
      logic r;
      r = 1'b0;
      for (int i = E_HI_LSB; i <= E_RSV_MSB; i++) begin
         if (i >= M_W - HI_SHIFT && e[i]) begin
            r = 1'b1;
         end
      end
      if (!HAS_PAT && e[E_PAT_4M]) begin
         r = 1'b1;
      end
      large_rsv = r;
   endfunction

   // physical bits 39:32 of a large page
   // bits at or above M stay zero; M is a build-time width
   function automatic logic [7:0] large_hi(input logic [ENTRY_W-1:0] e);
      logic [7:0] h;
      h = 8'h00;
      for (int k = 0; k < 8; k++) begin
         if (BASE_M + k < M_W) begin
            h[k] = e[E_HI_LSB + k];
         end
      end
      large_hi = h;
   endfunction

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   // arst_n asserts at once; its release is retimed so that
   // no flop leaves reset on a different edge from the rest
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // -----------------------------------------------------------------
   // register bus
   // -----------------------------------------------------------------
   logic [63:0]       directory_base_reg;
   logic [CTRL_W-1:0] ctrl;
   logic              bus_ack;
   logic              last_fault;
   law_state_t        state;

   // one wait cycle per access; the answer is ready on the second edge
   // trade-off: one extra cycle buys registered read data
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= (avs_read | avs_write) & ~bus_ack;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // merged control word; only its low bits are kept
   logic [31:0]       ctrl_word;
   assign ctrl_word = merge({27'h0000000, ctrl}, avs_writedata, avs_byteenable);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         directory_base_reg <= BASE_RESET;
         ctrl               <= CTRL_RESET;
      end else if (avs_write && bus_ack) begin
         case (avs_address)
            REG_BASE_LO_IDX: begin
               directory_base_reg[31:0] <= merge(directory_base_reg[31:0],
                                                 avs_writedata, avs_byteenable);
            end
            REG_BASE_HI_IDX: begin
               directory_base_reg[63:32] <= merge(directory_base_reg[63:32],
                                                  avs_writedata, avs_byteenable);
            end
            REG_CTRL_IDX: begin
               ctrl <= ctrl_word[CTRL_W-1:0];
            end
            // status is read-only; writes to it are dropped
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !bus_ack) begin
         case (avs_address)
            REG_BASE_LO_IDX: avs_readdata <= directory_base_reg[31:0];
            REG_BASE_HI_IDX: avs_readdata <= directory_base_reg[63:32];
            REG_CTRL_IDX:    avs_readdata <= {27'h0000000, ctrl};
            REG_STATUS_IDX:  avs_readdata <= {28'h0000000, last_fault, state,
                                               (state != LAW_IDLE)};
            default:         avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // walk sequencer
   // -----------------------------------------------------------------
   logic [ENTRY_W-1:0] dir_entry;
   logic               walk_on;
   logic               dir_large;

   // base bits 2:0, 11:5 and 63:32 never reach the walk
   assign walk_on   = ctrl[CTRL_TRANSLATION_ON] & ~ctrl[CTRL_WIDE_ENTRY];
   assign dir_large = ctrl[CTRL_LARGE_PAGE] & mem_rd_data[E_SIZE];
   // one walk at a time: ready is simply the idle state
   // supervisor_write_protect is stored only; rights checks
   // belong to the requester
   assign req_ready = (state == LAW_IDLE);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= LAW_IDLE;
      end else begin
         case (state)
            LAW_IDLE: begin
               if (req_valid) begin
                  // translation off answers at once, untranslated
                  state <= walk_on ? LAW_DIR : LAW_RESP;
               end
            end
            LAW_DIR: begin
               if (mem_rd_ack) begin
                  if (!mem_rd_data[E_PRESENT] || dir_large) begin
                     state <= LAW_RESP;
                  end else begin
                     state <= LAW_TBL;
                  end
               end
            end
            LAW_TBL: begin
               if (mem_rd_ack) begin
                  state <= LAW_RESP;
               end
            end
            // hold here until the core takes the answer
            LAW_RESP: begin
               if (rsp_ready) begin
                  state <= LAW_IDLE;
               end
            end
            default: state <= LAW_IDLE;
         endcase
      end
   end

   // memory read port; linear address is held by the core meanwhile
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_req                <= 1'b0;
         mem_rd_addr               <= '0;
         mem_rd_write_through_attr <= 1'b0;
         mem_rd_cache_disable_attr <= 1'b0;
         dir_entry                 <= '0;
      end else begin
         if (state == LAW_IDLE && req_valid && walk_on) begin
            mem_rd_req  <= 1'b1;
            mem_rd_addr <= entry_addr(directory_base_reg[31:12],
                                      req_lin_addr[31:LIN_DIR_LSB]);
            mem_rd_write_through_attr <= directory_base_reg[E_PWT];
            mem_rd_cache_disable_attr <= directory_base_reg[E_PCD];
         end else if (state == LAW_DIR && mem_rd_ack) begin
            dir_entry  <= mem_rd_data;
            mem_rd_req <= mem_rd_data[E_PRESENT] & ~dir_large;
            mem_rd_addr <= entry_addr(mem_rd_data[31:E_FRAME_LSB],
                                      req_lin_addr[21:LIN_TBL_LSB]);
            // table reads use the directory entry's memory type
            mem_rd_write_through_attr <= mem_rd_data[E_PWT];
            mem_rd_cache_disable_attr <= mem_rd_data[E_PCD];
         end else if (mem_rd_ack) begin
            mem_rd_req <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // response
   // -----------------------------------------------------------------
   // attributes of the final entry; a zero rw/us at either level wins
   task automatic load_attr(input logic [ENTRY_W-1:0] e, input logic up_ok_w,
                            input logic up_ok_u, input logic memtype_index_bit);
      rsp_write_permit       <= e[E_WRITE] & up_ok_w;
      rsp_user_permit        <= e[E_USER] & up_ok_u;
      rsp_write_through_attr <= e[E_PWT];
      rsp_cache_disable_attr <= e[E_PCD];
      rsp_accessed           <= e[E_ACC];
      rsp_dirty              <= e[E_DIRTY];
      rsp_global             <= e[E_GLOBAL] & ctrl[CTRL_GLOBAL_PAGES];
      rsp_memtype_index_bit  <= memtype_index_bit & HAS_PAT;
   endtask

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid              <= 1'b0;
         rsp_phys_addr          <= '0;
         rsp_fault              <= 1'b0;
         rsp_untranslated       <= 1'b0;
         rsp_large_page         <= 1'b0;
         rsp_write_permit       <= 1'b0;
         rsp_user_permit        <= 1'b0;
         rsp_write_through_attr <= 1'b0;
         rsp_cache_disable_attr <= 1'b0;
         rsp_memtype_index_bit  <= 1'b0;
         rsp_accessed           <= 1'b0;
         rsp_dirty              <= 1'b0;
         rsp_global             <= 1'b0;
         last_fault             <= 1'b0;
      end else begin
         if (state == LAW_RESP && rsp_ready) begin
            rsp_valid <= 1'b0;
         end
         if (state == LAW_IDLE && req_valid && !walk_on) begin
            // translation off: address passes through unmapped
            rsp_valid        <= 1'b1;
            rsp_untranslated <= 1'b1;
            rsp_fault        <= 1'b0;
            rsp_large_page   <= 1'b0;
            rsp_phys_addr    <= {8'h00, req_lin_addr};
            load_attr('0, 1'b1, 1'b1, 1'b0);
         end else if (state == LAW_DIR && mem_rd_ack &&
                      (!mem_rd_data[E_PRESENT] || dir_large)) begin
            // reserved bits fault, but the mapped address is
            // still shown so software can see what was decoded
            rsp_valid        <= 1'b1;
            rsp_untranslated <= 1'b0;
            rsp_large_page   <= dir_large & mem_rd_data[E_PRESENT];
            rsp_fault        <= !mem_rd_data[E_PRESENT] ||
                                large_rsv(mem_rd_data);
            last_fault       <= !mem_rd_data[E_PRESENT] || large_rsv(mem_rd_data);
            rsp_phys_addr    <= {large_hi(mem_rd_data),
                                 mem_rd_data[31:E_LARGE_LSB],
                                 req_lin_addr[21:0]};
            load_attr(mem_rd_data, 1'b1, 1'b1, mem_rd_data[E_PAT_4M]);
         end else if (state == LAW_TBL && mem_rd_ack) begin
            rsp_valid        <= 1'b1;
            rsp_untranslated <= 1'b0;
            rsp_large_page   <= 1'b0;
            rsp_fault        <= !mem_rd_data[E_PRESENT] ||
                                (!HAS_PAT && mem_rd_data[E_PAT_4K]);
            last_fault       <= !mem_rd_data[E_PRESENT] ||
                                (!HAS_PAT && mem_rd_data[E_PAT_4K]);
            rsp_phys_addr    <= {8'h00, mem_rd_data[31:E_FRAME_LSB],
                                 req_lin_addr[11:0]};
            load_attr(mem_rd_data, dir_entry[E_WRITE], dir_entry[E_USER],
                      mem_rd_data[E_PAT_4K]);
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/law_walk_props.sv
// assertions on the page walker's response and memory-read ports
// assumes it is bound to law_walk and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module law_walk_props
   import law_pkg::*;
(
   input wire logic               ref_clk,
   input wire logic               arst_n,
   input wire logic               req_valid,
   input wire logic               req_ready,
   input wire logic [LIN_W-1:0]   req_lin_addr,
   input wire logic               rsp_valid,
   input wire logic               rsp_ready,
   input wire logic [PHYS_W-1:0]  rsp_phys_addr,
   input wire logic               rsp_fault,
   input wire logic               rsp_untranslated,
   input wire logic               rsp_large_page,
   input wire logic               mem_rd_req,
   input wire logic [PHYS_W-1:0]  mem_rd_addr,
   input wire logic               mem_rd_ack,
   input wire logic [ENTRY_W-1:0] mem_rd_data
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_dir_index: assert property (
      req_valid && req_ready ##1 mem_rd_req |-> mem_rd_addr[11:2] == req_lin_addr[31:22])
      else $error("directory index wrong");
   a_upper_zero: assert property (
      mem_rd_req |-> mem_rd_addr[39:32] == 8'h00 && mem_rd_addr[1:0] == 2'h0)
      else $error("entry read address not clean");
   a_table_addr: assert property (
      mem_rd_req && mem_rd_ack ##1 mem_rd_req |->
      mem_rd_addr[31:2] == {$past(mem_rd_data[31:12]), req_lin_addr[21:12]})
      else $error("table entry address wrong");
   a_pass_thru: assert property (
      rsp_valid && rsp_untranslated |-> rsp_phys_addr == {8'h00, req_lin_addr})
      else $error("untranslated address wrong");
   a_small_page: assert property (
      rsp_valid && !rsp_untranslated && !rsp_large_page && !rsp_fault |->
      rsp_phys_addr[39:32] == 8'h00 && rsp_phys_addr[11:0] == req_lin_addr[11:0])
      else $error("small page address wrong");
   a_large_addr: assert property (
      mem_rd_req && mem_rd_ack ##1 rsp_valid && rsp_large_page |-> rsp_phys_addr ==
      {$past(mem_rd_data[20:13]), $past(mem_rd_data[31:22]), req_lin_addr[21:0]})
      else $error("large page address wrong");
   a_rsp_hold: assert property (
      rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_phys_addr) && $stable(rsp_fault))
      else $error("response changed before taken");
   a_rsp_once: assert property (
      rsp_valid && rsp_ready |=> !rsp_valid)
      else $error("response repeated");
   a_busy_refuse: assert property (
      rsp_valid || mem_rd_req |-> !req_ready)
      else $error("request accepted while busy");
   a_ack_next: assert property (
      mem_rd_req && mem_rd_ack |=> mem_rd_req || rsp_valid)
      else $error("walk stalled after entry read");
   a_mem_hold: assert property (
      mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
      else $error("entry read dropped early");
   c_large: cover property (rsp_valid && rsp_ready && rsp_large_page);
   c_fault: cover property (rsp_valid && rsp_ready && rsp_fault);
   c_small: cover property (rsp_valid && !rsp_large_page && !rsp_fault && !rsp_untranslated);
endmodule
bind law_walk law_walk_props law_walk_props_i (.*);
`default_nettype wire

// >>> tb/law_mem_model.sv
// memory holding paging entries; answers each entry read with a one-cycle ack
// assumes the bench fills the entry array before each walk
`timescale 1ns/10ps
`default_nettype none
module law_mem_model
   import law_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   input  wire logic               slow,
   input  wire logic               mem_rd_req,
   input  wire logic [PHYS_W-1:0]  mem_rd_addr,
   output logic                    mem_rd_ack,
   output logic [ENTRY_W-1:0]      mem_rd_data
);
   logic [ENTRY_W-1:0] mem [logic [PHYS_W-1:0]];
   logic [2:0]         wait_cnt;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_rd_ack  <= 1'b0;
         mem_rd_data <= 32'h00000000;
         wait_cnt    <= 3'h0;
      end else begin
         mem_rd_ack  <= 1'b0;
         // data toggles outside the ack cycle so a late sample cannot pass
         mem_rd_data <= ~mem_rd_data;
         if (mem_rd_req && !mem_rd_ack) begin
            wait_cnt <= wait_cnt + 3'h1;
            if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
               mem_rd_ack  <= 1'b1;
               mem_rd_data <= mem.exists(mem_rd_addr) ? mem[mem_rd_addr] : 32'h00000000;
               wait_cnt    <= 3'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/test_linear_addr_walk_32bit.sv
// self-checking bench for the page walker with a memory model on the far side
// assumes the walker's default parameters (40-bit width, extended pages, attribute index)
`timescale 1ns/10ps
`default_nettype none
module test_linear_addr_walk_32bit
   import law_pkg::*;
;
   localparam logic [31:0] BASE = 32'h00012FEF;
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [1:0]  avs_address = 2'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, req_ready, rsp_valid, mem_rd_req, mem_rd_ack;
   logic        req_valid = 1'b0;
   logic        rsp_ready = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] req_lin_addr = 32'h00000000;
   logic [39:0] rsp_phys_addr, mem_rd_addr;
   logic [31:0] mem_rd_data;
   logic        rsp_fault, rsp_untranslated, rsp_large_page, rsp_write_permit;
   logic        rsp_user_permit, rsp_write_through_attr, rsp_cache_disable_attr;
   logic        rsp_memtype_index_bit, rsp_accessed, rsp_dirty, rsp_global;
   logic        mem_rd_write_through_attr, mem_rd_cache_disable_attr;
   logic [31:0] rnd = 32'h000164F3;
   logic        dir_rd = 1'b0;
   logic [50:0] exp_q[$];
   logic [50:0] msk_q[$];
   int          errors = 0;
   int          checks_done = 0;
   law_walk law_walk_i (.*);
   law_mem_model law_mem_model_i (.ref_clk(ref_clk), .arst_n(arst_n), .slow(slow),
      .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
      .mem_rd_data(mem_rd_data));
   always #2 ref_clk = ~ref_clk;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_rsp(input logic [50:0] got, input logic [50:0] e, input logic [50:0] k);
      checks_done++;
      if ((got & k) !== (e & k)) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got & k, e & k);
      end
   endtask
   task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge ref_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // address stays put until the response is taken
   task automatic do_req(input logic [31:0] lin, input logic [50:0] e, input logic [50:0] k);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_lin_addr <= lin;
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      exp_q.push_back(e);
      msk_q.push_back(k);
      dir_rd = 1'b1;
      req_valid <= 1'b0;
      while (exp_q.size() != 0) @(posedge ref_clk);
   endtask
   // ------------------------------------------------------------
   // stall source and response monitor
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      rsp_ready <= rnd[3] | rnd[7] | !rsp_ready;
      slow <= rnd[5];
      if (mem_rd_req && mem_rd_ack && dir_rd) begin
         check_val({30'h0, mem_rd_write_through_attr, mem_rd_cache_disable_attr}, 32'h2);
         dir_rd = 1'b0;
      end
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
         if (exp_q.size() == 0)
            check_val(32'h1, 32'h0);
         else
            check_rsp({rsp_phys_addr, rsp_fault, rsp_untranslated, rsp_large_page,
               rsp_write_permit, rsp_user_permit, rsp_write_through_attr,
               rsp_cache_disable_attr, rsp_memtype_index_bit, rsp_accessed, rsp_dirty,
               rsp_global}, exp_q.pop_front(), msk_q.pop_front());
      end
   end
   initial begin
      #80000;
      errors++;
      final_report;
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q, lin, directory_entry, table_entry;
      logic [4:0]  ctrl;
      logic [2:0]  m;
      logic [50:0] e, k;
      logic [39:0] da;
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bus(1'b0, REG_BASE_LO_IDX, 32'h0, q);
      check_val(q, 32'h0);
      bus(1'b1, REG_BASE_LO_IDX, BASE, q);
      bus(1'b1, REG_BASE_HI_IDX, 32'hFFFFFFFF, q);
      bus(1'b1, REG_STATUS_IDX, 32'hFFFFFFFF, q);
      bus(1'b0, REG_BASE_LO_IDX, 32'h0, q);
      check_val(q, BASE);
      bus(1'b0, REG_STATUS_IDX, 32'h0, q);
      check_val(q & 32'hF, 32'h0);
      for (int i = 0; i < 60; i++) begin
         m = 3'(i % 6);
         rnd = lfsr_next(rnd); lin = rnd;
         rnd = lfsr_next(rnd); directory_entry = rnd;
         rnd = lfsr_next(rnd); table_entry = rnd;
         ctrl = {rnd[4], rnd[3], m != 3, m == 1, m != 0};
         directory_entry[0] = (m != 5);
         directory_entry[7] = (m == 3 || m == 4);
         table_entry[0] = 1'b1;
         directory_entry[21] = (m == 4) & rnd[9] & rnd[10];
         if (m != 4)
            directory_entry[31:12] = {12'h080, 8'(i)};
         law_mem_model_i.mem.delete();
         da = {8'h00, BASE[31:12], lin[31:22], 2'h0};
         law_mem_model_i.mem[da] = directory_entry;
         law_mem_model_i.mem[{8'h00, directory_entry[31:12], lin[21:12], 2'h0}] = table_entry;
         k = {51{1'b1}};
         if (m < 2) begin
            e = {8'h00, lin, 2'h1, 9'h000};
            k = {{42{1'b1}}, 9'h000};
         end else if (m == 5) begin
            e = {40'h0, 2'h2, 9'h000};
            k = {40'h0, 2'h3, 9'h000};
         end else if (m == 4) begin
            e = {directory_entry[20:13], directory_entry[31:22], lin[21:0], directory_entry[21], 2'h1, directory_entry[1], directory_entry[2], directory_entry[3],
                 directory_entry[4], directory_entry[12], directory_entry[5], directory_entry[6], directory_entry[8] & ctrl[3]};
            if (directory_entry[21])
               k = {{43{1'b1}}, 8'h00};
         end else begin
            e = {8'h00, table_entry[31:12], lin[11:0], 3'h0, directory_entry[1] & table_entry[1], directory_entry[2] & table_entry[2],
                 table_entry[3], table_entry[4], table_entry[7], table_entry[5], table_entry[6], table_entry[8] & ctrl[3]};
         end
         bus(1'b1, REG_CTRL_IDX, {rnd[31:5], ctrl}, q);
         bus(1'b0, REG_CTRL_IDX, 32'h0, q);
         check_val(q, {27'h0, ctrl});
         do_req(lin, e, k);
      end
      check_val(exp_q.size(), 32'h0);
      final_report;
   end
endmodule
`default_nettype wire
